// ==== ckgmo_clock_ctrl.sv ====
// Purpose: Clock gating and main oscillator control behind an AXI4-Lite slave
// Assumes: One clock at 40 MHz, synchronous active-low reset
// Notes:   Slow clock ticks come from a divider of clk
// Behaviour
// - Ones written to output-disable bits 8..10 stop those outputs
// - Protected registers ignore writes while the write-protect bit is set
// - Output-state bits read one while the matching output runs
// - Ones written to enable bits 8..31 start those peripheral clocks
// - Bits for absent peripherals change nothing
// - Ones written to disable bits stop those peripheral clocks
// - Peripheral-state bits read one while that clock runs
// - Oscillator writes apply only with key 0x37 in bits 16..23
// - Crystal ready rises only after the programmed start-up wait
// - Bypass sets crystal ready at once
// - Clearing crystal enable and bypass clears crystal ready
// - Writing one to bit 2 requests wait mode; bit is write-only
// - RC ready rises after RC start-up; clearing the enable stops it
// - Crystal start-up wait is field value times eight slow ticks
// - Source select picks crystal when one, RC when zero
// - RC codes 0, 1, 2 select 12, 8 and 4 MHz
`timescale 1ns/100ps
`default_nettype none
`include "ckgmo_consts.svh"
module ckgmo_clock_ctrl #(
   parameter int          SLOW_DIV    = `CKGMO_CLK_HZ / `CKGMO_SLOW_HZ,
   parameter logic [31:0] PERIPH_MASK = 32'hFFFF_FF00,
   parameter int          RC_STARTUP  = `CKGMO_RC_STARTUP_SLOW
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic [31:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [31:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output logic [2:0]                progOutRun,
   output logic [31:0]               periphClockBit,
   output logic                      crystalEnable,
   output logic                      crystalBypass,
   output logic                      rcOscEnable,
   output ckgmo_pkg::ckgmo_rcfreq_t  rcFreqSelect,
   output logic                      mainSourceSelect,
   output logic                      clockFailDetectEnable,
   output logic                      slowCrystalMonitorEnable,
   output logic                      crystalReadyFlag,
   output logic                      rcReadyFlag,
   output logic                      enterSleepCmd,
   output logic                      writeProtectOn
);
   localparam int XTW = 11;

   if (SLOW_DIV < 2 || SLOW_DIV > 65535) begin : g_chk_div
      $error("SLOW_DIV out of range");
   end
   if (PERIPH_MASK[7:0] != 8'h00) begin : g_chk_mask
      $error("Peripheral bits 0..7 do not exist");
   end
   if (RC_STARTUP < 1 || RC_STARTUP > 2047) begin : g_chk_rc
      $error("RC_STARTUP out of range");
   end

   // Address decode shared by read and write paths
   function automatic ckgmo_pkg::ckgmo_reg_t regDecode(input logic [31:0] a);
      if (a == `CKGMO_ADDR_SCER) regDecode = ckgmo_pkg::CKGMO_REG_SCER;
      else if (a == `CKGMO_ADDR_SCDR) regDecode = ckgmo_pkg::CKGMO_REG_SCDR;
      else if (a == `CKGMO_ADDR_SCSR) regDecode = ckgmo_pkg::CKGMO_REG_SCSR;
      else if (a == `CKGMO_ADDR_PCER) regDecode = ckgmo_pkg::CKGMO_REG_PCER;
      else if (a == `CKGMO_ADDR_PCDR) regDecode = ckgmo_pkg::CKGMO_REG_PCDR;
      else if (a == `CKGMO_ADDR_PCSR) regDecode = ckgmo_pkg::CKGMO_REG_PCSR;
      else if (a == `CKGMO_ADDR_MOR) regDecode = ckgmo_pkg::CKGMO_REG_MOR;
      else if (a == `CKGMO_ADDR_STAT) regDecode = ckgmo_pkg::CKGMO_REG_STAT;
      else if (a == `CKGMO_ADDR_WPMR) regDecode = ckgmo_pkg::CKGMO_REG_WPMR;
      else regDecode = ckgmo_pkg::CKGMO_REG_NONE;
   endfunction : regDecode

   ckgmo_pkg::ckgmo_wr_state_t wrState_ff;
   logic                       awHeld_ff;
   logic                       wHeld_ff;
   logic [31:0]                awAddr_ff;
   logic [31:0]                wData_ff;
   logic [3:0]                 wStrb_ff;
   logic [1:0]                 bResp_ff;
   logic [31:0]                rData_ff;
   logic [1:0]                 rResp_ff;
   logic                       rValid_ff;
   logic [2:0]                 progOut_ff;
   logic [31:0]                periph_ff;
   logic                       xtEn_ff;
   logic                       xtBy_ff;
   logic                       rcEn_ff;
   logic [2:0]                 rcFreq_ff;
   logic [7:0]                 xtStart_ff;
   logic                       srcSel_ff;
   logic                       clock_fail_detect_enable_ff;
   logic                       xt32Mon_ff;
   logic                       sleep_ff;
   logic                       wProt_ff;
   logic [15:0]                slowCnt_ff;
   logic                       slowTick_ff;
   logic                       xtReady;
   logic                       rcReady;

   // Write decode
   logic                       wrDo;
   ckgmo_pkg::ckgmo_reg_t      wrReg;
   logic [31:0]                wMask;
   logic [31:0]                wEff;
   logic                       wrOpen;
   logic                       wrScer;
   logic                       wrScdr;
   logic                       wrPcer;
   logic                       wrPcdr;
   logic                       wrMor;
   logic                       morKeyOk;
   logic [31:0]                morRead;
   logic [31:0]                morNew;
   logic [31:0]                statRead;
   assign wrDo     = (wrState_ff == ckgmo_pkg::CKGMO_WR_COLLECT) && awHeld_ff && wHeld_ff;
   assign wrReg    = regDecode(awAddr_ff);
   assign wMask    = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
   assign wEff     = wData_ff & wMask;
   assign wrOpen   = wrDo && !wProt_ff;
   assign wrScer   = wrOpen && (wrReg == ckgmo_pkg::CKGMO_REG_SCER);
   assign wrScdr   = wrOpen && (wrReg == ckgmo_pkg::CKGMO_REG_SCDR);
   assign wrPcer   = wrOpen && (wrReg == ckgmo_pkg::CKGMO_REG_PCER);
   assign wrPcdr   = wrOpen && (wrReg == ckgmo_pkg::CKGMO_REG_PCDR);
   assign morKeyOk = wEff[`CKGMO_MOR_KEY_LSB +: 8] == `CKGMO_MOR_KEY;
   assign wrMor    = wrOpen && (wrReg == ckgmo_pkg::CKGMO_REG_MOR) && morKeyOk;
   // Unstrobed bytes keep their old contents
   assign morNew   = (morRead & ~wMask) | wEff;

   // Oscillator register image; key and wait bits read zero
   assign morRead = {5'h00, xt32Mon_ff, clock_fail_detect_enable_ff, srcSel_ff, 8'h00, xtStart_ff,
                     1'b0, rcFreq_ff, rcEn_ff, 1'b0, xtBy_ff, xtEn_ff};
   assign statRead = {30'h0000_0000, rcReady, xtReady};

   // Read decode
   ckgmo_pkg::ckgmo_reg_t      rdReg;
   logic [31:0]                rdMux;
   logic [31:0]                progWord;
   assign rdReg    = regDecode(s_axi_araddr);
   assign progWord = {21'h00_0000, progOut_ff, 8'h00};
   // Write-only registers read zero
   assign rdMux = (rdReg == ckgmo_pkg::CKGMO_REG_SCSR) ? progWord :
                  (rdReg == ckgmo_pkg::CKGMO_REG_PCSR) ? periph_ff :
                  (rdReg == ckgmo_pkg::CKGMO_REG_MOR)  ? morRead :
                  (rdReg == ckgmo_pkg::CKGMO_REG_STAT) ? statRead :
                  (rdReg == ckgmo_pkg::CKGMO_REG_WPMR) ? {31'h0000_0000, wProt_ff} :
                  `CKGMO_RST_ZERO32;

   // Channel handshakes; one write and one read in flight at most
   assign s_axi_awready = (wrState_ff == ckgmo_pkg::CKGMO_WR_COLLECT) && !awHeld_ff;
   assign s_axi_wready  = (wrState_ff == ckgmo_pkg::CKGMO_WR_COLLECT) && !wHeld_ff;
   assign s_axi_bvalid  = (wrState_ff == ckgmo_pkg::CKGMO_WR_RESP);
   assign s_axi_bresp   = bResp_ff;
   assign s_axi_arready = !rValid_ff;
   assign s_axi_rvalid  = rValid_ff;
   assign s_axi_rdata   = rData_ff;
   assign s_axi_rresp   = rResp_ff;

   // Write address and data may arrive in either order
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wrState_ff <= ckgmo_pkg::CKGMO_WR_COLLECT;
         awHeld_ff  <= 1'b0;
         wHeld_ff   <= 1'b0;
         awAddr_ff  <= `CKGMO_RST_ZERO32;
         wData_ff   <= `CKGMO_RST_ZERO32;
         wStrb_ff   <= 4'h0;
         bResp_ff   <= `CKGMO_RESP_OKAY;
      end else begin
         case (wrState_ff)
            ckgmo_pkg::CKGMO_WR_COLLECT: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  awHeld_ff <= 1'b1;
                  awAddr_ff <= s_axi_awaddr;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  wHeld_ff <= 1'b1;
                  wData_ff <= s_axi_wdata;
                  wStrb_ff <= s_axi_wstrb;
               end
               if (wrDo) begin
                  awHeld_ff  <= 1'b0;
                  wHeld_ff   <= 1'b0;
                  wrState_ff <= ckgmo_pkg::CKGMO_WR_RESP;
                  bResp_ff   <= (wrReg == ckgmo_pkg::CKGMO_REG_NONE) ?
                                `CKGMO_RESP_DECERR : `CKGMO_RESP_OKAY;
               end
            end
            ckgmo_pkg::CKGMO_WR_RESP: begin
               if (s_axi_bready) begin
                  wrState_ff <= ckgmo_pkg::CKGMO_WR_COLLECT;
               end
            end
            default: wrState_ff <= ckgmo_pkg::CKGMO_WR_COLLECT;
         endcase
      end
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rValid_ff <= 1'b0;
         rData_ff  <= `CKGMO_RST_ZERO32;
         rResp_ff  <= `CKGMO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_ff <= 1'b1;
         rData_ff  <= rdMux;
         rResp_ff  <= (rdReg == ckgmo_pkg::CKGMO_REG_NONE) ?
                      `CKGMO_RESP_DECERR : `CKGMO_RESP_OKAY;
      end else if (s_axi_rready) begin
         rValid_ff <= 1'b0;
      end
   end

   // Programmable outputs; a disable beats nothing since one write hits one register
   for (genvar gi = 0; gi < `CKGMO_PROG_NUM; gi++) begin : g_prog
      always_ff @(posedge clk) begin
         if (!reset_n) begin
            progOut_ff[gi] <= 1'b0;
         end else if (wrScdr && wEff[`CKGMO_PROG_LSB + gi]) begin
            progOut_ff[gi] <= 1'b0;
         end else if (wrScer && wEff[`CKGMO_PROG_LSB + gi]) begin
            progOut_ff[gi] <= 1'b1;
         end
      end
   end

   // Peripheral gates; absent peripherals stay off for good
   for (genvar gp = 0; gp < 32; gp++) begin : g_pid
      if (PERIPH_MASK[gp]) begin : g_on
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               periph_ff[gp] <= 1'b0;
            end else if (wrPcer && wEff[gp]) begin
               periph_ff[gp] <= 1'b1;
            end else if (wrPcdr && wEff[gp]) begin
               periph_ff[gp] <= 1'b0;
            end
         end
      end else begin : g_off
         always_ff @(posedge clk) begin
            periph_ff[gp] <= 1'b0;
         end
      end
   end

   // Oscillator controls; a wrong key drops the whole word
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         xtEn_ff    <= 1'b0;
         xtBy_ff    <= 1'b0;
         rcEn_ff    <= `CKGMO_RST_RCEN;
         rcFreq_ff  <= `CKGMO_RST_RCF;
         xtStart_ff <= 8'h00;
         srcSel_ff  <= 1'b0;
         clock_fail_detect_enable_ff   <= 1'b0;
         xt32Mon_ff <= 1'b0;
         sleep_ff   <= 1'b0;
      end else begin
         sleep_ff <= wrMor && wEff[`CKGMO_MOR_WAIT];
         if (wrMor) begin
            xtEn_ff    <= morNew[`CKGMO_MOR_XTEN];
            xtBy_ff    <= morNew[`CKGMO_MOR_XTBY];
            rcEn_ff    <= morNew[`CKGMO_MOR_RCEN];
            rcFreq_ff  <= morNew[`CKGMO_MOR_RCF_LSB +: 3];
            xtStart_ff <= morNew[`CKGMO_MOR_XTST_LSB +: 8];
            srcSel_ff  <= morNew[`CKGMO_MOR_SEL];
            clock_fail_detect_enable_ff   <= morNew[`CKGMO_MOR_CFD];
            xt32Mon_ff <= morNew[`CKGMO_MOR_XT32];
         end
      end
   end

   // Write protect is never itself protected
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wProt_ff <= 1'b0;
      end else if (wrDo && wrReg == ckgmo_pkg::CKGMO_REG_WPMR && wStrb_ff[0]) begin
         wProt_ff <= wData_ff[`CKGMO_WPMR_EN];
      end
   end

   // Slow clock tick from clk; cheaper than a second domain
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         slowCnt_ff  <= 16'h0000;
         slowTick_ff <= 1'b0;
      end else if (slowCnt_ff == 16'(SLOW_DIV - 1)) begin
         slowCnt_ff  <= 16'h0000;
         slowTick_ff <= 1'b1;
      end else begin
         slowCnt_ff  <= slowCnt_ff + 16'h0001;
         slowTick_ff <= 1'b0;
      end
   end

   // Start-up timers; bypass only reaches the crystal side
   logic [XTW-1:0] xtTarget;
   assign xtTarget = XTW'(xtStart_ff) * XTW'(`CKGMO_XT_MULT);

   ckgmo_startup_timer #(.TW(XTW)) u_xt_timer (
      .clk      (clk),
      .reset_n  (reset_n),
      .enable   (xtEn_ff),
      .bypass   (xtBy_ff),
      .slowTick (slowTick_ff),
      .target   (xtTarget),
      .ready    (xtReady)
   );

   ckgmo_startup_timer #(.TW(XTW)) u_rc_timer (
      .clk      (clk),
      .reset_n  (reset_n),
      .enable   (rcEn_ff),
      .bypass   (1'b0),
      .slowTick (slowTick_ff),
      .target   (XTW'(RC_STARTUP)),
      .ready    (rcReady)
   );

   // Outputs
   assign progOutRun               = progOut_ff;
   assign periphClockBit           = periph_ff;
   assign crystalEnable            = xtEn_ff;
   assign crystalBypass            = xtBy_ff;
   assign rcOscEnable              = rcEn_ff;
   assign rcFreqSelect             = ckgmo_pkg::ckgmo_rcfreq_t'(rcFreq_ff);
   assign mainSourceSelect         = srcSel_ff;
   assign clockFailDetectEnable    = clock_fail_detect_enable_ff;
   assign slowCrystalMonitorEnable = xt32Mon_ff;
   assign crystalReadyFlag         = xtReady;
   assign rcReadyFlag              = rcReady;
   assign enterSleepCmd            = sleep_ff;
   assign writeProtectOn           = wProt_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_disable_stops: assert property (
      wrDo && !wProt_ff && wrReg == ckgmo_pkg::CKGMO_REG_SCDR && wEff[9] |=> !progOut_ff[1])
      else $error("output stayed on after disable");
   a_protect_holds: assert property (
      wrDo && wProt_ff |=> $stable(periph_ff) && $stable(progOut_ff) && $stable(morRead))
      else $error("protected write took effect");
   a_out_state_read: assert property (
      s_axi_arvalid && s_axi_arready && rdReg == ckgmo_pkg::CKGMO_REG_SCSR
      |=> s_axi_rvalid && s_axi_rdata[10:8] == $past(progOut_ff))
      else $error("output state read wrong");
   a_enable_starts: assert property (
      wrPcer && wEff[31] |=> periph_ff[31])
      else $error("peripheral clock not started");
   a_absent_off: assert property (
      (periph_ff & ~PERIPH_MASK) == 32'h0000_0000)
      else $error("absent peripheral clock on");
   a_disable_periph: assert property (
      wrPcdr && wEff[12] && !wEff[8] |=> !periph_ff[12] && periph_ff[8] == $past(periph_ff[8]))
      else $error("peripheral disable wrong");
   a_periph_read: assert property (
      s_axi_arvalid && s_axi_arready && rdReg == ckgmo_pkg::CKGMO_REG_PCSR
      |=> s_axi_rdata == $past(periph_ff))
      else $error("peripheral state read wrong");
   a_bad_key_drop: assert property (
      wrDo && wrReg == ckgmo_pkg::CKGMO_REG_MOR && !morKeyOk |=> $stable(morRead))
      else $error("oscillator write without key applied");
   a_key_reads_zero: assert property (
      s_axi_arvalid && s_axi_arready && rdReg == ckgmo_pkg::CKGMO_REG_MOR
      |=> s_axi_rdata[23:16] == 8'h00 && !s_axi_rdata[2])
      else $error("key or wait bit read nonzero");
   a_sleep_pulse: assert property (
      sleep_ff |=> !sleep_ff || $past(wrMor))
      else $error("sleep request longer than the write");
   a_rc_off: assert property (
      !rcEn_ff ##1 !rcEn_ff |-> !rcReady)
      else $error("RC ready while RC off");
   a_wo_reads_zero: assert property (
      s_axi_arvalid && s_axi_arready && rdReg == ckgmo_pkg::CKGMO_REG_PCER
      |=> s_axi_rdata == 32'h0000_0000)
      else $error("write-only register read nonzero");

   c_pcer_write: cover property (wrPcer);
   c_key_write: cover property (wrMor && wEff[0]);
   c_xt_ready: cover property ($rose(xtReady) && !xtBy_ff);
   c_protected: cover property (wrDo && wProt_ff);
endmodule : ckgmo_clock_ctrl
`default_nettype wire

// ==== ckgmo_consts.svh ====
// Purpose: Offsets, field positions, reset values and timing for the clock controller
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only
`ifndef CKGMO_CONSTS_SVH
`define CKGMO_CONSTS_SVH

// Register byte addresses
`define CKGMO_ADDR_SCER      32'h400E_0400
`define CKGMO_ADDR_SCDR      32'h400E_0404
`define CKGMO_ADDR_SCSR      32'h400E_0408
`define CKGMO_ADDR_PCER      32'h400E_0410
`define CKGMO_ADDR_PCDR      32'h400E_0414
`define CKGMO_ADDR_PCSR      32'h400E_0418
`define CKGMO_ADDR_MOR       32'h400E_0420
`define CKGMO_ADDR_STAT      32'h400E_0468
`define CKGMO_ADDR_WPMR      32'h400E_04E4

// Programmable output bits sit at 8..10
`define CKGMO_PROG_LSB       8
`define CKGMO_PROG_NUM       3

// Oscillator register fields
`define CKGMO_MOR_XTEN       0
`define CKGMO_MOR_XTBY       1
`define CKGMO_MOR_WAIT       2
`define CKGMO_MOR_RCEN       3
`define CKGMO_MOR_RCF_LSB    4
`define CKGMO_MOR_XTST_LSB   8
`define CKGMO_MOR_KEY_LSB    16
`define CKGMO_MOR_SEL        24
`define CKGMO_MOR_CFD        25
`define CKGMO_MOR_XT32       26
`define CKGMO_MOR_KEY        8'h37

// Status and protect fields
`define CKGMO_STAT_XTRDY     0
`define CKGMO_STAT_RCRDY     1
`define CKGMO_WPMR_EN        0

// Reset values
`define CKGMO_RST_RCEN       1'b1
`define CKGMO_RST_RCF        3'h0
`define CKGMO_RST_ZERO32     32'h0000_0000

// Timing
`define CKGMO_CLK_HZ         40000000
`define CKGMO_SLOW_HZ        32768
`define CKGMO_XT_MULT        8
`define CKGMO_RC_STARTUP_SLOW 8

// AXI responses
`define CKGMO_RESP_OKAY      2'h0
`define CKGMO_RESP_DECERR    2'h3

`endif

// ==== ckgmo_pkg.sv ====
// Purpose: Types shared by the clock controller files
// Assumes: Nothing
// Notes:   Constants live in ckgmo_consts.svh
package ckgmo_pkg;

   // Register selected by an address
   typedef enum {
      CKGMO_REG_NONE,
      CKGMO_REG_SCER,
      CKGMO_REG_SCDR,
      CKGMO_REG_SCSR,
      CKGMO_REG_PCER,
      CKGMO_REG_PCDR,
      CKGMO_REG_PCSR,
      CKGMO_REG_MOR,
      CKGMO_REG_STAT,
      CKGMO_REG_WPMR
   } ckgmo_reg_t;

   // RC oscillator frequency codes
   typedef enum logic [2:0] {
      CKGMO_RC_12MHZ = 3'h0,
      CKGMO_RC_8MHZ  = 3'h1,
      CKGMO_RC_4MHZ  = 3'h2
   } ckgmo_rcfreq_t;

   // Write channel state
   typedef enum {
      CKGMO_WR_COLLECT,
      CKGMO_WR_RESP
   } ckgmo_wr_state_t;

endpackage : ckgmo_pkg

// ==== ckgmo_startup_timer.sv ====
// Purpose: Oscillator start-up wait counted in slow-clock ticks
// Assumes: slowTick is a one-cycle pulse on clk
// Notes:   Bypass makes ready at once
`timescale 1ns/100ps
`default_nettype none
module ckgmo_startup_timer #(
   parameter int TW = 11
) (
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          enable,
   input  wire logic          bypass,
   input  wire logic          slowTick,
   input  wire logic [TW-1:0] target,
   output logic               ready
);
   logic [TW-1:0] count_ff;
   logic          enPrev_ff;
   logic          ready_ff;

   if (TW < 1) begin : g_chk
      $error("TW must be at least 1");
   end

   assign ready = ready_ff;

   // Restart on every enable edge so a stale count never leaks through
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count_ff  <= '0;
         ready_ff  <= 1'b0;
         enPrev_ff <= 1'b0;
      end else begin
         enPrev_ff <= enable;
         if (bypass) begin
            ready_ff <= 1'b1;
            count_ff <= '0;
         end else if (!enable || !enPrev_ff) begin
            ready_ff <= 1'b0;
            count_ff <= '0;
         end else if (!ready_ff && count_ff >= target) begin
            ready_ff <= 1'b1;
         end else if (!ready_ff && slowTick) begin
            count_ff <= count_ff + TW'(1);
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_ready_after_wait: assert property (
      $rose(ready_ff) && !bypass |-> $past(count_ff) >= $past(target))
      else $error("ready rose before the start-up wait");
   a_ready_drops_off: assert property (
      !enable && !bypass |=> !ready_ff)
      else $error("ready stayed up with oscillator off");
   a_bypass_ready: assert property (
      bypass |=> ready_ff)
      else $error("bypass did not give ready");
endmodule : ckgmo_startup_timer
`default_nettype wire

// ==== ckgmo_tb.sv ====
// Purpose: Self-checking bench for the clock controller register slave
// Assumes: Slow divider and RC start-up shortened so the run stays brief
// Notes:   Every access goes through the AXI4-Lite tasks below
`timescale 1ns/100ps
`default_nettype none
`include "ckgmo_consts.svh"
module tb;
   localparam logic [31:0] K = 32'h0037_0000;
   logic        clk = 1'b0, resetN = 1'b0;
   logic [31:0] awA = '0, wD = '0, arA = '0, rD;
   logic        awV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0, rR = 1'b0;
   logic        awRdy, wRdy, bV, arRdy, rV, sleepPulse, sel, xtRdy;
   logic        sleepSeen = 1'b0;
   logic        xtEnO, xtByO, rcEnO, cfdO, monO, rcRdy, wpOn;
   logic [31:0] pcb;
   logic [1:0]  rResp, bResp;
   logic [2:0]  prog;
   ckgmo_pkg::ckgmo_rcfreq_t rcf;
   int          nMismatch = 0, checked = 0, cyc = 0;

   // Divider of 4 keeps start-up waits to tens of cycles
   ckgmo_clock_ctrl #(.SLOW_DIV(4), .RC_STARTUP(1)) DUT (
      .clk(clk), .reset_n(resetN), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
      .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV),
      .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bR),
      .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rD),
      .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR), .progOutRun(prog),
      .periphClockBit(pcb), .crystalEnable(xtEnO), .crystalBypass(xtByO), .rcOscEnable(rcEnO),
      .rcFreqSelect(rcf), .mainSourceSelect(sel), .clockFailDetectEnable(cfdO),
      .slowCrystalMonitorEnable(monO), .crystalReadyFlag(xtRdy), .rcReadyFlag(rcRdy),
      .enterSleepCmd(sleepPulse), .writeProtectOn(wpOn));

   always #12.5 clk = ~clk;

   // Pulse is one cycle long, so latch it
   always @(posedge clk) begin
      cyc++;
      if (sleepPulse === 1'b1) sleepSeen <= 1'b1;
      if (cyc == 20000) begin
         nMismatch++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         nMismatch++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      awA <= a;
      wD <= d;
      awV <= 1'b1;
      wV <= 1'b1;
      bR <= 1'b1;
      do begin
         @(posedge clk);
         if (awV & awRdy) awV <= 1'b0;
         if (wV & wRdy) wV <= 1'b0;
      end while (bV !== 1'b1);
      bR <= 1'b0;
   endtask : wr

   // Read and compare in one call
   task automatic rc(input logic [31:0] a, input logic [31:0] e);
      @(posedge clk);
      arA <= a;
      arV <= 1'b1;
      rR <= 1'b1;
      do begin
         @(posedge clk);
         if (arV & arRdy) arV <= 1'b0;
      end while (rV !== 1'b1);
      rR <= 1'b0;
      chk(rD, e);
   endtask : rc

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, nMismatch);
      if (nMismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test

   // Register sequences with expected values
   initial begin
      repeat (4) @(posedge clk);
      resetN <= 1'b1;
      rc(`CKGMO_ADDR_MOR, 32'h0000_0008);
      wr(`CKGMO_ADDR_PCER, 32'hFFFF_FFFF);
      rc(`CKGMO_ADDR_PCSR, 32'hFFFF_FF00);
      wr(`CKGMO_ADDR_PCDR, 32'h0000_F0FF);
      rc(`CKGMO_ADDR_PCSR, 32'hFFFF_0F00);
      chk(pcb, 32'hFFFF_0F00);
      wr(`CKGMO_ADDR_WPMR, 32'h0000_0001);
      chk({31'h0, wpOn}, 32'h1);
      wr(`CKGMO_ADDR_PCDR, 32'hFFFF_FFFF);
      wr(`CKGMO_ADDR_SCER, 32'h0000_0700);
      rc(`CKGMO_ADDR_PCSR, 32'hFFFF_0F00);
      rc(`CKGMO_ADDR_SCSR, 32'h0000_0000);
      wr(`CKGMO_ADDR_WPMR, 32'h0000_0000);
      wr(`CKGMO_ADDR_SCER, 32'h0000_0700);
      wr(`CKGMO_ADDR_SCDR, 32'h0000_0200);
      wr(`CKGMO_ADDR_SCSR, 32'h0000_0000);
      rc(`CKGMO_ADDR_SCSR, 32'h0000_0500);
      chk({29'h0, prog}, 32'h5);
      rc(`CKGMO_ADDR_PCER, 32'h0000_0000);
      rc(32'h400E_040C, 32'h0000_0000);
      chk({30'h0, rResp}, 32'h3);
      wr(`CKGMO_ADDR_MOR, K | 32'h0000_0209);
      rc(`CKGMO_ADDR_STAT, 32'h0000_0002);
      rc(`CKGMO_ADDR_MOR, 32'h0000_0209);
      wr(`CKGMO_ADDR_MOR, 32'h0036_0008);
      rc(`CKGMO_ADDR_MOR, 32'h0000_0209);
      repeat (100) @(posedge clk);
      rc(`CKGMO_ADDR_STAT, 32'h0000_0003);
      wr(`CKGMO_ADDR_MOR, K | 32'h0000_0008);
      rc(`CKGMO_ADDR_STAT, 32'h0000_0002);
      wr(`CKGMO_ADDR_MOR, K | 32'h0000_000A);
      // Ready is launched on the response edge, so look one edge later
      @(posedge clk);
      chk({31'h0, xtRdy}, 32'h1);
      chk({30'h0, xtByO, xtEnO}, 32'h2);
      wr(`CKGMO_ADDR_MOR, K | 32'h0100_001C);
      rc(`CKGMO_ADDR_MOR, 32'h0100_0018);
      chk({31'h0, sleepSeen}, 32'h1);
      chk({28'h0, sel, rcf}, 32'h9);
      // RC off with its frequency left alone
      wr(`CKGMO_ADDR_MOR, K | 32'h0710_0010);
      rc(`CKGMO_ADDR_STAT, 32'h0000_0000);
      chk({28'h0, cfdO, monO, rcEnO, rcRdy}, 32'hC);
      wr(32'h400E_040C, 32'h0000_0000);
      chk({30'h0, bResp}, 32'h3);
      stop_test();
   end
endmodule : tb
`default_nettype wire
